// ==== hdl/tce_pkg.sv ====
// Contract
// - synchronous exceptions report mcause codes 0 to 7 by kind
// - environment call gives code 8 from user mode, 0xb from machine mode
// - software, timer, external interrupts report 0x80000003, 0x80000007, 0x8000000b
// - fast interrupt channels 0 to 15 report 0x80000010 through 0x8000001f
// - illegal instruction loads mtval with the offending instruction word
// - bus fault monitor holds an error code naming the fault cause
// - no response within the access window is flagged as timeout fault
// - protection refusal reports an access fault with protection cause
package tce_pkg;
   localparam logic [31:0] TCE_MC_I_MISAL = 32'h0000_0000;
   localparam logic [31:0] TCE_MC_I_ACC = 32'h0000_0001;
   localparam logic [31:0] TCE_MC_ILLEGAL = 32'h0000_0002;
   localparam logic [31:0] TCE_MC_BREAK = 32'h0000_0003;
   localparam logic [31:0] TCE_MC_L_MISAL = 32'h0000_0004;
   localparam logic [31:0] TCE_MC_L_ACC = 32'h0000_0005;
   localparam logic [31:0] TCE_MC_S_MISAL = 32'h0000_0006;
   localparam logic [31:0] TCE_MC_S_ACC = 32'h0000_0007;
   localparam logic [31:0] TCE_MC_ECALL_U = 32'h0000_0008;
   localparam logic [31:0] TCE_MC_ECALL_M = 32'h0000_000b;
   localparam logic [31:0] TCE_MC_MSI = 32'h8000_0003;
   localparam logic [31:0] TCE_MC_MTI = 32'h8000_0007;
   localparam logic [31:0] TCE_MC_MEI = 32'h8000_000b;
   localparam logic [31:0] TCE_MC_FIRQ0 = 32'h8000_0010;
   localparam int TCE_NUM_FIRQ = 16;
   localparam int TCE_TIMEOUT_CYC = 15;

   // fault cause codes held by the bus fault monitor
   typedef enum logic [1:0] {
      TCE_ERR_NONE = 2'h0,
      TCE_ERR_TIMEOUT = 2'h1,
      TCE_ERR_DEVICE = 2'h2,
      TCE_ERR_PROT = 2'h3
   } tce_err_t;

   typedef enum logic [1:0] {
      TCE_ACC_INSTR = 2'h0,
      TCE_ACC_LOAD = 2'h1,
      TCE_ACC_STORE = 2'h2
   } tce_acc_t;

   // synchronous exception requests from the core, one bit each
   typedef struct packed {
      logic i_misal;
      logic illegal;
      logic brk;
      logic l_misal;
      logic s_misal;
      logic ecall;
   } tce_exc_t;

   // machine interrupt requests
   typedef struct packed {
      logic msi;
      logic mti;
      logic mei;
      logic [15:0] firq;
   } tce_irq_t;

   // bus access watched by the monitor
   typedef struct packed {
      logic req;
      tce_acc_t acc;
      logic ack;
      logic err;
      logic prot;
   } tce_bus_t;
endpackage

// ==== hdl/tce_bus_fault_monitor.sv ====
`timescale 1ns/1ns
module tce_bus_fault_monitor #(
   parameter int TIMEOUT_CYC = tce_pkg::TCE_TIMEOUT_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire tce_pkg::tce_bus_t bus_in,
   output logic fault_out,
   output tce_pkg::tce_acc_t fault_acc_out,
   output tce_pkg::tce_err_t err_code_out
);
   localparam int CW = $clog2(TIMEOUT_CYC + 1);
   logic busy_q;
   logic [CW-1:0] cnt_q;
   tce_pkg::tce_acc_t acc_q;
   tce_pkg::tce_err_t code_q;
   logic fault_q;

   // protection is checked before the access is issued, so it fails at once
   wire prot_hit = bus_in.req && bus_in.prot;
   wire dev_hit = busy_q && bus_in.err;
   wire tmo_hit = busy_q && !bus_in.ack && !bus_in.err && (cnt_q == CW'(TIMEOUT_CYC - 1));
   wire done = busy_q && (bus_in.ack || bus_in.err || tmo_hit);
   wire any_fault = prot_hit || dev_hit || tmo_hit;
   wire tce_pkg::tce_err_t code_d = prot_hit ? tce_pkg::TCE_ERR_PROT :
      dev_hit ? tce_pkg::TCE_ERR_DEVICE :
      tce_pkg::TCE_ERR_TIMEOUT;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         busy_q <= 1'b0;
         cnt_q <= '0;
         acc_q <= tce_pkg::TCE_ACC_INSTR;
         code_q <= tce_pkg::TCE_ERR_NONE;
         fault_q <= 1'b0;
      end else begin
         fault_q <= any_fault;
         if (bus_in.req && !prot_hit) begin
            busy_q <= 1'b1;
            cnt_q <= '0;
            acc_q <= bus_in.acc;
         end else if (done) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            cnt_q <= cnt_q + CW'(1);
         end
         if (prot_hit) begin
            acc_q <= bus_in.acc;
         end
         if (any_fault) begin
            code_q <= code_d;
         end
      end
   end

   assign fault_out = fault_q;
   assign fault_acc_out = acc_q;
   assign err_code_out = code_q;

   AST_TIMEOUT: assert property (@(posedge clk_in) disable iff (rst_in)
      tmo_hit && !bus_in.req |=> fault_out && err_code_out == tce_pkg::TCE_ERR_TIMEOUT)
      else $error("timeout not flagged");
   AST_DEVICE: assert property (@(posedge clk_in) disable iff (rst_in)
      dev_hit && !bus_in.prot |=> fault_out && err_code_out == tce_pkg::TCE_ERR_DEVICE)
      else $error("device error not flagged");
   AST_PROT: assert property (@(posedge clk_in) disable iff (rst_in)
      prot_hit |=> fault_out && err_code_out == tce_pkg::TCE_ERR_PROT)
      else $error("protection fault not flagged");
   AST_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_fault |=> $stable(err_code_out))
      else $error("fault code changed without a fault");
endmodule

// ==== hdl/tce_trap_cause.sv ====
`timescale 1ns/1ns
module tce_trap_cause #(
   parameter int TIMEOUT_CYC = tce_pkg::TCE_TIMEOUT_CYC
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire tce_pkg::tce_exc_t exc_in,
   input wire logic user_mode_in,
   input wire logic [31:0] instr_in,
   input wire logic [31:0] addr_in,
   input wire tce_pkg::tce_irq_t irq_in,
   input wire tce_pkg::tce_bus_t bus_in,
   output logic trap_out,
   output logic [31:0] mcause_out,
   output logic [31:0] mtval_out,
   output tce_pkg::tce_err_t bus_err_out
);
   logic bus_fault;
   tce_pkg::tce_acc_t bus_acc;
   logic trap_q;
   logic [31:0] mcause_q;
   logic [31:0] mtval_q;

   tce_bus_fault_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .bus_in(bus_in),
      .fault_out(bus_fault),
      .fault_acc_out(bus_acc),
      .err_code_out(bus_err_out)
   );

   function automatic logic [31:0] firq_code(input logic [15:0] req);
      logic [31:0] c;
      c = tce_pkg::TCE_MC_FIRQ0;
      for (int i = tce_pkg::TCE_NUM_FIRQ - 1; i >= 0; i--) begin
         if (req[i]) begin
            c = tce_pkg::TCE_MC_FIRQ0 + 32'(i);
         end
      end
      return c;
   endfunction

   wire [31:0] acc_code = (bus_acc == tce_pkg::TCE_ACC_LOAD) ? tce_pkg::TCE_MC_L_ACC :
      (bus_acc == tce_pkg::TCE_ACC_STORE) ? tce_pkg::TCE_MC_S_ACC : tce_pkg::TCE_MC_I_ACC;
   wire [31:0] ecall_code = user_mode_in ? tce_pkg::TCE_MC_ECALL_U : tce_pkg::TCE_MC_ECALL_M;
   wire any_exc = (|exc_in) || bus_fault;
   wire any_irq = irq_in.msi || irq_in.mti || irq_in.mei || (|irq_in.firq);
   // exceptions outrank interrupts; priority among exceptions fixed here
   wire [31:0] exc_code = bus_fault ? acc_code :
      exc_in.i_misal ? tce_pkg::TCE_MC_I_MISAL :
      exc_in.illegal ? tce_pkg::TCE_MC_ILLEGAL :
      exc_in.brk ? tce_pkg::TCE_MC_BREAK :
      exc_in.ecall ? ecall_code :
      exc_in.l_misal ? tce_pkg::TCE_MC_L_MISAL : tce_pkg::TCE_MC_S_MISAL;
   wire [31:0] irq_code = irq_in.mei ? tce_pkg::TCE_MC_MEI :
      irq_in.msi ? tce_pkg::TCE_MC_MSI :
      irq_in.mti ? tce_pkg::TCE_MC_MTI : firq_code(irq_in.firq);
   wire take_illegal = !bus_fault && !exc_in.i_misal && exc_in.illegal;
   wire [31:0] mcause_d = any_exc ? exc_code : irq_code;
   // illegal keeps the instruction word; other exceptions report the address
   wire [31:0] mtval_d = take_illegal ? instr_in : (any_exc ? addr_in : '0);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         trap_q <= 1'b0;
         mcause_q <= '0;
         mtval_q <= '0;
      end else begin
         trap_q <= any_exc || any_irq;
         if (any_exc || any_irq) begin
            mcause_q <= mcause_d;
            mtval_q <= mtval_d;
         end
      end
   end

   assign trap_out = trap_q;
   assign mcause_out = mcause_q;
   assign mtval_out = mtval_q;

   // exception causes; each case holds the higher-priority sources off
   AST_I_MISAL: assert property (@(posedge clk_in) disable iff (rst_in)
      exc_in == 6'b100000 && !bus_fault
      |=> mcause_out == tce_pkg::TCE_MC_I_MISAL && mtval_out == $past(addr_in))
      else $error("bad misaligned fetch cause");

   AST_ILLEGAL: assert property (@(posedge clk_in) disable iff (rst_in)
      exc_in == 6'b010000 && !bus_fault
      |=> mcause_out == tce_pkg::TCE_MC_ILLEGAL && mtval_out == $past(instr_in))
      else $error("illegal instruction not reported");

   AST_BREAK: assert property (@(posedge clk_in) disable iff (rst_in)
      exc_in == 6'b001000 && !bus_fault
      |=> mcause_out == tce_pkg::TCE_MC_BREAK)
      else $error("bad breakpoint cause");

   AST_L_MISAL: assert property (@(posedge clk_in) disable iff (rst_in)
      exc_in == 6'b000100 && !bus_fault
      |=> mcause_out == tce_pkg::TCE_MC_L_MISAL)
      else $error("bad misaligned load cause");

   AST_S_MISAL: assert property (@(posedge clk_in) disable iff (rst_in)
      exc_in == 6'b000010 && !bus_fault
      |=> mcause_out == tce_pkg::TCE_MC_S_MISAL)
      else $error("bad misaligned store cause");

   AST_ECALL: assert property (@(posedge clk_in) disable iff (rst_in)
      exc_in == 6'b000001 && !bus_fault
      |=> mcause_out == ($past(user_mode_in) ? tce_pkg::TCE_MC_ECALL_U : tce_pkg::TCE_MC_ECALL_M))
      else $error("bad environment call cause");

   AST_ECALL_U: assert property (@(posedge clk_in) disable iff (rst_in)
      exc_in == 6'b000001 && !bus_fault && user_mode_in
      |=> mcause_out == tce_pkg::TCE_MC_ECALL_U)
      else $error("bad user environment call cause");

   AST_ECALL_M: assert property (@(posedge clk_in) disable iff (rst_in)
      exc_in == 6'b000001 && !bus_fault && !user_mode_in
      |=> mcause_out == tce_pkg::TCE_MC_ECALL_M)
      else $error("bad machine environment call cause");

   AST_EXC_BIT31: assert property (@(posedge clk_in) disable iff (rst_in)
      any_exc
      |=> trap_out && !mcause_out[31] && (mcause_out <= tce_pkg::TCE_MC_S_ACC ||
         mcause_out == tce_pkg::TCE_MC_ECALL_U || mcause_out == tce_pkg::TCE_MC_ECALL_M))
      else $error("bad exception cause");

   // mtval carries the address for every exception but an illegal instruction
   AST_EXC_MTVAL: assert property (@(posedge clk_in) disable iff (rst_in)
      any_exc && !take_illegal
      |=> mtval_out == $past(addr_in))
      else $error("exception value is not the faulting address");

   // interrupt causes
   AST_MSI: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_exc && irq_in.msi && !irq_in.mei
      |=> mcause_out == tce_pkg::TCE_MC_MSI)
      else $error("bad software interrupt cause");

   AST_MTI: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_exc && irq_in.mti && !irq_in.mei && !irq_in.msi
      |=> mcause_out == tce_pkg::TCE_MC_MTI)
      else $error("bad timer interrupt cause");

   AST_MEI: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_exc && irq_in.mei
      |=> mcause_out == tce_pkg::TCE_MC_MEI)
      else $error("bad external interrupt cause");

   AST_IRQ_BIT31: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_exc && any_irq
      |=> trap_out && mcause_out[31])
      else $error("interrupt cause without bit 31");

   AST_IRQ_MTVAL: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_exc && any_irq
      |=> mtval_out == 32'h0)
      else $error("interrupt left a nonzero trap value");

   // exceptions outrank interrupts
   AST_EXC_OVER_IRQ: assert property (@(posedge clk_in) disable iff (rst_in)
      any_exc && any_irq
      |=> !mcause_out[31])
      else $error("interrupt taken over a pending exception");

   // fast channels: lowest index wins
   AST_FIRQ0: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_exc && !irq_in.mei && !irq_in.msi && !irq_in.mti && irq_in.firq[0]
      |=> mcause_out == tce_pkg::TCE_MC_FIRQ0)
      else $error("bad first fast interrupt cause");

   AST_FIRQ: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_exc && !irq_in.mei && !irq_in.msi && !irq_in.mti && irq_in.firq == 16'h8000
      |=> mcause_out == 32'h8000_001f)
      else $error("bad fast interrupt cause");

   AST_FIRQ_RANGE: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_exc && !irq_in.mei && !irq_in.msi && !irq_in.mti && (|irq_in.firq)
      |=> mcause_out >= tce_pkg::TCE_MC_FIRQ0 &&
         mcause_out < tce_pkg::TCE_MC_FIRQ0 + 32'(tce_pkg::TCE_NUM_FIRQ))
      else $error("fast interrupt cause out of range");

   // bus faults by access type; the monitor holds the cause
   AST_BUS_INSTR: assert property (@(posedge clk_in) disable iff (rst_in)
      bus_fault && bus_acc == tce_pkg::TCE_ACC_INSTR
      |=> mcause_out == tce_pkg::TCE_MC_I_ACC)
      else $error("bus fault not mapped to instruction access fault");

   AST_BUS_LOAD: assert property (@(posedge clk_in) disable iff (rst_in)
      bus_fault && bus_acc == tce_pkg::TCE_ACC_LOAD
      |=> mcause_out == tce_pkg::TCE_MC_L_ACC)
      else $error("bus fault not mapped to load access fault");

   AST_BUSACC: assert property (@(posedge clk_in) disable iff (rst_in)
      bus_fault && bus_acc == tce_pkg::TCE_ACC_STORE
      |=> mcause_out == tce_pkg::TCE_MC_S_ACC)
      else $error("bus fault not mapped to store access fault");

   AST_BUS_MTVAL: assert property (@(posedge clk_in) disable iff (rst_in)
      bus_fault
      |=> mtval_out == $past(addr_in))
      else $error("bus fault value is not the faulting address");

   AST_BUS_CODE: assert property (@(posedge clk_in) disable iff (rst_in)
      bus_fault
      |-> bus_err_out != tce_pkg::TCE_ERR_NONE)
      else $error("bus fault without a held cause code");

   // trap strobe and held values
   AST_TRAP_SET: assert property (@(posedge clk_in) disable iff (rst_in)
      any_exc || any_irq
      |=> trap_out)
      else $error("trap source without trap strobe");

   AST_TRAP_CLR: assert property (@(posedge clk_in) disable iff (rst_in)
      !any_exc && !any_irq
      |=> !trap_out && $stable(mcause_out) && $stable(mtval_out))
      else $error("trap state moved without a source");
endmodule

// ==== sim/tce_bus_model.sv ====
`timescale 1ns/1ns
// mode 0 acks, 1 answers with error, 2 stays silent
module tce_bus_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic req_in,
   input wire logic prot_in,
   input wire logic [1:0] mode_in,
   input wire logic [3:0] delay_in,
   output logic ack_out,
   output logic err_out
);
   logic [3:0] cnt_q;
   logic busy_q;
   // a refused access never reaches the module
   wire start = req_in && !prot_in && mode_in != 2'h2;
   wire fin = busy_q && cnt_q == 4'h0;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= 4'h0;
         busy_q <= 1'h0;
      end else if (start) begin
         cnt_q <= delay_in;
         busy_q <= 1'h1;
      end else if (fin) begin
         busy_q <= 1'h0;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
   assign ack_out = fin && mode_in == 2'h0;
   assign err_out = fin && mode_in == 2'h1;
endmodule

// ==== sim/tb.sv ====
`timescale 1ns/1ns
module tb;
   localparam int TO = 3;
   localparam logic [31:0] INS = 32'h0000_1537;
   localparam logic [31:0] ADR = 32'hffff_ff70;
   logic clk_in = 1'h0;
   logic rst_in = 1'h1;
   tce_pkg::tce_exc_t exc = '0;
   tce_pkg::tce_irq_t irq = '0;
   tce_pkg::tce_acc_t acc = tce_pkg::TCE_ACC_INSTR;
   tce_pkg::tce_bus_t bus;
   tce_pkg::tce_err_t be;
   logic um = 1'h0, req = 1'h0, prot = 1'h0, ack, err, trap;
   logic [1:0] mode = 2'h0;
   logic [31:0] mc, mt;
   int errors = 0;
   int num_checks = 0;
   always #2 clk_in = ~clk_in;
   assign bus = '{req, acc, ack, err, prot};
   tce_trap_cause #(.TIMEOUT_CYC(TO)) dut (.clk_in(clk_in), .rst_in(rst_in), .exc_in(exc), .user_mode_in(um),
      .instr_in(INS), .addr_in(ADR), .irq_in(irq), .bus_in(bus), .trap_out(trap), .mcause_out(mc),
      .mtval_out(mt), .bus_err_out(be));
   tce_bus_model model (.clk_in(clk_in), .rst_in(rst_in), .req_in(req), .prot_in(prot), .mode_in(mode),
      .delay_in(4'h1), .ack_out(ack), .err_out(err));
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic exc_case(input tce_pkg::tce_exc_t e, input logic u, input tce_pkg::tce_irq_t q,
      input logic [31:0] xm, input logic [31:0] xt);
      @(posedge clk_in) #1;
      exc = e;
      um = u;
      irq = q;
      @(posedge clk_in) #1;
      exc = '0;
      irq = '0;
      chk("trap", 32'h1, {31'h0, trap});
      chk("mcause", xm, mc);
      chk("mtval", xt, mt);
      @(posedge clk_in) #1;
      chk("trap_end", 32'h0, {31'h0, trap});
   endtask
   task automatic bus_case(input tce_pkg::tce_acc_t a, input logic [1:0] m, input logic p,
      input logic [31:0] xm, input tce_pkg::tce_err_t xe, input int xn);
      int n;
      @(posedge clk_in) #1;
      req = 1'h1;
      acc = a;
      mode = m;
      prot = p;
      @(posedge clk_in) #1;
      req = 1'h0;
      prot = 1'h0;
      n = 1;
      // bounded: a lost fault must not hang the run
      while (trap !== 1'h1 && n < 12) begin
         @(posedge clk_in) #1;
         n++;
      end
      if (xn > 0) chk("latency", 32'(xn), 32'(n));
      if (xe == tce_pkg::TCE_ERR_NONE) chk("no_trap", 32'h0, {31'h0, trap});
      else begin
         chk("mcause", xm, mc);
         chk("mtval", ADR, mt);
         chk("bus_err", 32'(xe), 32'(be));
      end
      repeat (6) @(posedge clk_in);
   endtask
   task automatic test_sync();
      exc_case(6'h20, 1'h0, '0, 32'h0, ADR);
      exc_case(6'h10, 1'h0, '0, 32'h2, INS);
      exc_case(6'h08, 1'h0, '0, 32'h3, ADR);
      exc_case(6'h04, 1'h0, '0, 32'h4, ADR);
      exc_case(6'h02, 1'h0, '0, 32'h6, ADR);
      exc_case(6'h01, 1'h1, '0, 32'h8, ADR);
      exc_case(6'h01, 1'h0, '0, 32'hb, ADR);
   endtask
   task automatic test_irq();
      exc_case('0, 1'h0, 19'h40000, 32'h8000_0003, 32'h0);
      exc_case('0, 1'h0, 19'h20000, 32'h8000_0007, 32'h0);
      exc_case('0, 1'h0, 19'h10000, 32'h8000_000b, 32'h0);
      for (int i = 0; i < 16; i++) begin
         exc_case('0, 1'h0, 19'(1 << i), 32'h8000_0010 + 32'(i), 32'h0);
      end
      exc_case('0, 1'h0, 19'h70000, 32'h8000_000b, 32'h0);
      exc_case('0, 1'h0, 19'h60000, 32'h8000_0003, 32'h0);
      exc_case('0, 1'h0, 19'h00003, 32'h8000_0010, 32'h0);
      exc_case(6'h10, 1'h0, 19'h20000, 32'h2, INS);
   endtask
   task automatic test_bus();
      bus_case(tce_pkg::TCE_ACC_LOAD, 2'h2, 1'h0, 32'h5, tce_pkg::TCE_ERR_TIMEOUT, TO + 2);
      bus_case(tce_pkg::TCE_ACC_STORE, 2'h1, 1'h0, 32'h7, tce_pkg::TCE_ERR_DEVICE, 4);
      bus_case(tce_pkg::TCE_ACC_INSTR, 2'h2, 1'h1, 32'h1, tce_pkg::TCE_ERR_PROT, 2);
      bus_case(tce_pkg::TCE_ACC_LOAD, 2'h0, 1'h0, 32'h0, tce_pkg::TCE_ERR_NONE, 0);
      chk("bus_err_held", 32'(tce_pkg::TCE_ERR_PROT), 32'(be));
   endtask
   task automatic test_reset();
      @(posedge clk_in) #1;
      rst_in = 1'h1;
      @(posedge clk_in) #1;
      chk("rst2_mcause", 32'h0, mc);
      chk("rst2_mtval", 32'h0, mt);
      chk("rst2_bus_err", 32'h0, 32'(be));
      rst_in = 1'h0;
      exc_case(6'h08, 1'h0, '0, 32'h3, ADR);
   endtask
   task automatic print_verdict();
      if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk_in);
      #1 rst_in = 1'h0;
      chk("rst_mcause", 32'h0, mc);
      chk("rst_mtval", 32'h0, mt);
      chk("rst_trap", 32'h0, {31'h0, trap});
      chk("rst_bus_err", 32'h0, 32'(be));
      test_sync();
      test_irq();
      test_bus();
      test_reset();
      print_verdict();
   end
   initial begin
      #20000;
      errors++;
      print_verdict();
   end
endmodule
